// ===== sim/crt_pin_src.sv
module crt_pin_src (
  input wire logic i_mclk,
  output logic o_count_pin,
  output logic o_trig_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_count_pin = 1'b1;
    o_trig_pin = 1'b1;
  end
  // ========
  // falls with each level held two machine cycles
  task automatic fall(input bit trig, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge i_mclk);
      if (trig) o_trig_pin <= 1'b0;
      else o_count_pin <= 1'b0;
      repeat (24) @(posedge i_mclk);
      if (trig) o_trig_pin <= 1'b1;
      else o_count_pin <= 1'b1;
      repeat (23) @(posedge i_mclk);
    end
  endtask
  // direction level on the trigger pin
  task automatic dir(input logic v);
    @(posedge i_mclk);
    o_trig_pin <= v;
    repeat (24) @(posedge i_mclk);
  endtask
endmodule

// ===== sim/crt_timer_monitor.sv
module crt_timer_monitor (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_count_pin,
  input wire logic i_trig_pin,
  input wire logic o_timer_irq,
  input wire logic o_baud_tick,
  input wire logic o_clock_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  // ========
  // mode register written since reset
  logic mode_wr_r;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) mode_wr_r <= 1'b0;
    else if (i_wr && i_addr == 3'h1) mode_wr_r <= 1'b1;
  end
  // ========
  property p_rd_idle;
    !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero");
  property p_unmapped;
    i_rd && i_addr[2:1] == 2'h3 |=> o_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_down_count_enable_rst;
    i_rd && i_addr == 3'h1 && !mode_wr_r |=> o_rdata == 8'h00;
  endproperty
  a_down_count_enable_rst: assert property (p_down_count_enable_rst)
    else $error("mode not zero after reset");
  property p_flag_irq;
    i_rd && i_addr == 3'h0 ##1 o_rdata[7] |-> o_timer_irq;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("overflow flag without irq");
  property p_irq_hold;
    o_timer_irq && !i_wr |=> o_timer_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("irq dropped without write");
  property p_irq_fall;
    $fell(o_timer_irq) |-> $past(i_wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell without write");
  property p_baud_pulse;
    o_baud_tick |=> !o_baud_tick;
  endproperty
  a_baud_pulse: assert property (p_baud_pulse)
    else $error("baud tick too long");
  property p_clk_out;
    $changed(o_clock_out) |=> $stable(o_clock_out);
  endproperty
  a_clk_out: assert property (p_clk_out)
    else $error("clock out toggled twice");
  c_irq: cover property (o_timer_irq);
  c_tick: cover property (o_baud_tick);
  c_clk: cover property ($rose(o_clock_out));
endmodule

bind crt_timer crt_timer_monitor mon_u (.i_mclk(i_mclk),
  .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_count_pin(i_count_pin), .i_trig_pin(i_trig_pin),
  .o_timer_irq(o_timer_irq), .o_baud_tick(o_baud_tick),
  .o_clock_out(o_clock_out));

// ===== sim/crt_timer_tb.sv
module crt_timer_tb import crt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = 1'b0, i_resetn = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, b, b0;
  logic o_timer_irq, o_baud_tick, o_clock_out, cpin, tpin;
  logic [15:0] r, v, w;
  int failures = 0, check_count = 0, n;
  always #50 i_mclk = ~i_mclk;
  crt_timer dut_u (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_count_pin(cpin), .i_trig_pin(tpin),
    .o_timer_irq(o_timer_irq), .o_baud_tick(o_baud_tick),
    .o_clock_out(o_clock_out));
  crt_pin_src src_u (.i_mclk(i_mclk), .o_count_pin(cpin),
    .o_trig_pin(tpin));
  // ========
  task stop_test;
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("Error %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_mclk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(negedge i_mclk);
    d = o_rdata;
  endtask
  task wr16(input logic [2:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 3'h1, d[15:8]);
  endtask
  task rd16(input logic [2:0] a, output logic [15:0] d);
    logic [7:0] l, h;
    rd(a, l);
    rd(a + 3'h1, h);
    d = {h, l};
  endtask
  // wait for irq (0) or baud tick (1)
  task wt(input bit s);
    int k;
    for (k = 0; k < 2000; k++) begin
      @(negedge i_mclk);
      if ((s ? o_baud_tick : o_timer_irq) === 1'b1) break;
    end
    if (k == 2000) begin
      failures++;
      stop_test();
    end
  endtask
  function automatic logic [15:0] step(input logic [15:0] c, rl,
    input bit up);
    if (up) return (c == 16'hFFFF) ? rl : c + 16'h0001;
    return (c == rl) ? 16'hFFFF : c - 16'h0001;
  endfunction
  // ========
  initial begin
    void'($urandom(32'hB200));
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], b);
      chk("reg", 16'h0000, {8'h00, b});
    end
    v = 16'($urandom_range(16'hEFFF));
    wr16(3'h2, v);
    wr(3'h0, 8'h04);
    rd(3'h2, b0);
    repeat (118) @(posedge i_mclk);
    rd(3'h2, b);
    chk("rate", {8'h00, b0 + 8'h0A}, {8'h00, b});
    r = 16'($urandom);
    wr(3'h0, 8'h00);
    wr16(3'h4, r);
    wr16(3'h2, 16'hFFFD);
    wr(3'h0, 8'h04);
    wt(0);
    rd16(3'h2, w);
    chk("reload", step(16'hFFFF, r, 1), w);
    rd(3'h0, b);
    chk("ctrl", 16'h0084, {8'h00, b});
    wr(3'h0, 8'h00);
    @(negedge i_mclk);
    chk("irq", 16'h0000, {15'h0, o_timer_irq});
    n = $urandom_range(5, 1);
    wr16(3'h2, 16'h0000);
    wr(3'h0, 8'h06);
    src_u.fall(0, n);
    repeat (36) @(posedge i_mclk);
    rd(3'h2, b);
    chk("events", 16'(n), {8'h00, b});
    for (int e = 0; e < 2; e++) begin
      v = 16'($urandom);
      wr(3'h0, 8'h00);
      wr16(3'h4, 16'h0000);
      wr16(3'h2, v);
      wr(3'h0, e ? 8'h09 : 8'h01);
      src_u.fall(1, 1);
      repeat (36) @(posedge i_mclk);
      rd16(3'h4, w);
      chk("capture", e ? v : 16'h0000, w);
      chk("irq", 16'(e), {15'h0, o_timer_irq});
    end
    r = 16'($urandom);
    wr(3'h0, 8'h00);
    wr16(3'h4, r);
    wr(3'h0, 8'h08);
    src_u.fall(1, 1);
    repeat (36) @(posedge i_mclk);
    rd16(3'h2, w);
    chk("trig_reload", r, w);
    r = 16'($urandom_range(16'hFFFE));
    wr(3'h0, 8'h00);
    wr16(3'h4, r);
    wr(3'h1, 8'h01);
    src_u.dir(1'b0);
    wr16(3'h2, r);
    wr(3'h0, 8'h04);
    wt(0);
    rd16(3'h2, w);
    chk("down", step(r, r, 0), w);
    wr(3'h0, 8'h40);
    rd(3'h0, b);
    chk("bit17", 16'h0040, {8'h00, b});
    chk("irq", 16'h0000, {15'h0, o_timer_irq});
    src_u.dir(1'b1);
    wr16(3'h2, 16'hFFFF);
    wr(3'h0, 8'h44);
    wt(0);
    rd16(3'h2, w);
    chk("up", step(16'hFFFF, r, 1), w);
    rd(3'h0, b);
    chk("bit17", 16'h0084, {8'h00, b});
    wr(3'h0, 8'h00);
    wr16(3'h4, 16'hFFF0);
    wr16(3'h2, 16'hFFF8);
    wr(3'h1, 8'h02);
    wr(3'h0, 8'h15);
    wt(1);
    rd(3'h0, b);
    wr(3'h0, 8'h00);
    chk("baud_ctrl", 16'h0015, {8'h00, b});
    rd(3'h3, b);
    chk("baud_hi", 16'h00FF, {8'h00, b});
    stop_test();
  end
endmodule

// ===== verilog/crt_map.svh
`ifndef CRT_MAP_SVH
`define CRT_MAP_SVH

// ==================================================
// register offsets
`define CRT_OFS_CTRL 3'h0
`define CRT_OFS_MODE 3'h1
`define CRT_OFS_CNT_LO 3'h2
`define CRT_OFS_CNT_HI 3'h3
`define CRT_OFS_RCAP_LO 3'h4
`define CRT_OFS_RCAP_HI 3'h5
// ==================================================
// control register fields
`define CRT_B_OVF 7
`define CRT_B_EXF 6
`define CRT_B_RXBAUD 5
`define CRT_B_TXBAUD 4
`define CRT_B_EXEN 3
`define CRT_B_RUN 2
`define CRT_B_CTS 1
`define CRT_B_CPRL 0
// mode register fields
`define CRT_B_CLKOE 1
`define CRT_B_DOWN_COUNT_ENABLE 0
// ==================================================
// reset values and count top
`define CRT_RST_BYTE 8'h00
`define CRT_RST_WORD 16'h0000
`define CRT_TOP 16'hFFFF
// ==================================================
// timing counts in oscillator clocks
`define CRT_MC_LEN 4'hC
`define CRT_SAMPLE_PH 4'h9
`define CRT_UPDATE_PH 4'h4
`endif

// ===== verilog/crt_phase_gen.sv
`include "crt_map.svh"
module crt_phase_gen
  import crt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  crt_phase_if.gen ph
);
  logic [3:0] phase_r;
  logic [3:0] phase_nxt;
  logic last_ph;

  // ==================================================
  // machine cycle of twelve clocks
  assign last_ph = (phase_r == (`CRT_MC_LEN - 4'h1));
  assign phase_nxt = last_ph ? 4'h0 : phase_r + 4'h1;
  assign ph.sample_stb = (phase_r == `CRT_SAMPLE_PH);
  assign ph.update_stb = (phase_r == `CRT_UPDATE_PH);
  assign ph.state_stb = phase_r[0];

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_nxt;
    end
  end
endmodule

// ===== verilog/crt_phase_if.sv
interface crt_phase_if;
  logic sample_stb;
  logic update_stb;
  logic state_stb;
  modport gen (output sample_stb, output update_stb, output state_stb);
  modport use_p (input sample_stb, input update_stb, input state_stb);
endinterface

// ===== verilog/crt_pin_sampler.sv
module crt_pin_sampler
  import crt_pkg::*;
#(
  parameter logic IDLE = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_pin,
  crt_phase_if.use_p ph,
  output logic o_level,
  output logic o_fall
);
  logic s1_r;
  logic s2_r;
  logic cur_r;
  logic fall_r;

  // ==================================================
  // two-flop sync, one sample per machine cycle
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_r <= IDLE;
      s2_r <= IDLE;
      cur_r <= IDLE;
      fall_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      if (ph.sample_stb) begin
        cur_r <= s2_r;
        fall_r <= cur_r & ~s2_r;
      end
    end
  end

  assign o_level = cur_r;
  assign o_fall = fall_r;
endmodule

// ===== verilog/crt_pkg.sv
package crt_pkg;
  typedef enum logic [1:0] {
    CRT_OFF,
    CRT_RELOAD,
    CRT_CAPTURE,
    CRT_BAUD
  } crt_mode_t;
endpackage

// ===== verilog/crt_timer.sv
// The plain strobed port and the register addresses are this design's own decisions.
`include "crt_map.svh"
module crt_timer
  import crt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_count_pin,
  input wire logic i_trig_pin,
  output logic o_timer_irq,
  output logic o_baud_tick,
  output logic o_clock_out
);
  // ==================================================
  // control state
  logic ovf_r;
  logic exf_r;
  logic rxbaud_r;
  logic txbaud_r;
  logic exen_r;
  logic run_r;
  logic cts_r;
  logic cprl_r;
  logic down_count_enable_r;
  logic clkoe_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] rcap_r;
  logic [15:0] rcap_nxt;
  logic [7:0] rdata_r;
  logic clk_out_r;
  logic baud_tick_r;
  logic ovf_nxt;
  logic exf_nxt;

  // ==================================================
  // phase strobes and pin samplers
  crt_phase_if ph ();

  crt_phase_gen u_phase (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .ph(ph.gen)
  );

  logic cnt_fall;
  logic trig_fall;
  logic trig_level;

  crt_pin_sampler #(.IDLE(1'b1)) u_count_pin (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_pin(i_count_pin),
    .ph(ph.use_p),
    .o_level(),
    .o_fall(cnt_fall)
  );

  crt_pin_sampler #(.IDLE(1'b1)) u_trig_pin (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_pin(i_trig_pin),
    .ph(ph.use_p),
    .o_level(trig_level),
    .o_fall(trig_fall)
  );

  // ==================================================
  // register decode
  logic wr_ctrl;
  logic wr_mode;
  logic wr_lo;
  logic wr_hi;
  logic wr_rlo;
  logic wr_rhi;
  assign wr_ctrl = i_wr && (i_addr == `CRT_OFS_CTRL);
  assign wr_mode = i_wr && (i_addr == `CRT_OFS_MODE);
  assign wr_lo = i_wr && (i_addr == `CRT_OFS_CNT_LO);
  assign wr_hi = i_wr && (i_addr == `CRT_OFS_CNT_HI);
  assign wr_rlo = i_wr && (i_addr == `CRT_OFS_RCAP_LO);
  assign wr_rhi = i_wr && (i_addr == `CRT_OFS_RCAP_HI);

  logic [7:0] ctrl_val;
  logic [7:0] mode_val;
  logic [7:0] rd_mux;
  assign ctrl_val = {ovf_r, exf_r, rxbaud_r, txbaud_r,
                     exen_r, run_r, cts_r, cprl_r};
  assign mode_val = {6'h00, clkoe_r, down_count_enable_r};
  assign rd_mux = (i_addr == `CRT_OFS_CTRL) ? ctrl_val :
                  (i_addr == `CRT_OFS_MODE) ? mode_val :
                  (i_addr == `CRT_OFS_CNT_LO) ? cnt_r[7:0] :
                  (i_addr == `CRT_OFS_CNT_HI) ? cnt_r[15:8] :
                  (i_addr == `CRT_OFS_RCAP_LO) ? rcap_r[7:0] :
                  (i_addr == `CRT_OFS_RCAP_HI) ? rcap_r[15:8] :
                  8'h00;

  // ==================================================
  // mode selection
  crt_mode_t mode;
  logic baud;
  logic fast;
  logic updn;
  logic dn;
  assign baud = rxbaud_r | txbaud_r;
  assign mode = !run_r ? CRT_OFF :
                baud ? CRT_BAUD :
                cprl_r ? CRT_CAPTURE : CRT_RELOAD;
  // state-time rate for baud and clock-out timing
  assign fast = baud | (clkoe_r & ~cts_r);
  // up/down only in plain auto-reload
  assign updn = down_count_enable_r & ~baud & ~cprl_r;
  assign dn = updn & ~trig_level;

  // ==================================================
  // count stepping
  logic tick;
  logic step;
  logic at_top;
  logic at_bot;
  logic wrap;
  assign tick = cts_r ? (cnt_fall & ph.update_stb) :
                fast ? ph.state_stb : ph.update_stb;
  assign step = (mode != CRT_OFF) & tick;
  assign at_top = (cnt_r == `CRT_TOP);
  assign at_bot = (cnt_r == rcap_r);
  assign wrap = step & (dn ? at_bot : at_top);

  logic [15:0] wrap_val;
  always_comb begin
    case (mode)
      CRT_RELOAD: wrap_val = dn ? `CRT_TOP : rcap_r;
      CRT_BAUD: wrap_val = rcap_r;
      CRT_CAPTURE: wrap_val = `CRT_RST_WORD;
      default: wrap_val = cnt_r;
    endcase
  end

  // ==================================================
  // trigger pin events
  logic trig;
  logic trig_reload;
  logic trig_capture;
  logic trig_flag;
  assign trig = exen_r & trig_fall & ph.update_stb;
  assign trig_reload = trig & ~cprl_r & ~baud & ~updn;
  assign trig_capture = trig & cprl_r & ~baud;
  assign trig_flag = trig & ~updn;

  logic [15:0] cnt_hw;
  assign cnt_hw = trig_reload ? rcap_r :
                  wrap ? wrap_val :
                  step ? (dn ? cnt_r - 16'h0001 : cnt_r + 16'h0001) :
                  cnt_r;

  // ==================================================
  // flags: hardware set wins over software clear
  logic ovf_set;
  logic exf_tgl;
  assign ovf_set = wrap & ~fast;
  assign exf_tgl = wrap & updn;

  always_comb begin
    ovf_nxt = ovf_r;
    if (ovf_set) begin
      ovf_nxt = 1'b1;
    end else if (wr_ctrl) begin
      ovf_nxt = i_wdata[`CRT_B_OVF];
    end
  end

  always_comb begin
    exf_nxt = exf_r;
    if (trig_flag) begin
      exf_nxt = 1'b1;
    end else if (exf_tgl) begin
      exf_nxt = ~exf_r;
    end else if (wr_ctrl) begin
      exf_nxt = i_wdata[`CRT_B_EXF];
    end
  end

  // ==================================================
  // count and capture-reload next values
  always_comb begin
    cnt_nxt = cnt_hw;
    if (wr_lo) begin
      cnt_nxt = {cnt_r[15:8], i_wdata};
    end else if (wr_hi) begin
      cnt_nxt = {i_wdata, cnt_r[7:0]};
    end
  end

  always_comb begin
    rcap_nxt = rcap_r;
    if (trig_capture) begin
      rcap_nxt = cnt_r;
    end else if (wr_rlo) begin
      rcap_nxt = {rcap_r[15:8], i_wdata};
    end else if (wr_rhi) begin
      rcap_nxt = {i_wdata, rcap_r[7:0]};
    end
  end

  // ==================================================
  // registers
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ovf_r <= 1'b0;
      exf_r <= 1'b0;
      rxbaud_r <= 1'b0;
      txbaud_r <= 1'b0;
      exen_r <= 1'b0;
      run_r <= 1'b0;
      cts_r <= 1'b0;
      cprl_r <= 1'b0;
      down_count_enable_r <= 1'b0;
      clkoe_r <= 1'b0;
    end else begin
      ovf_r <= ovf_nxt;
      exf_r <= exf_nxt;
      if (wr_ctrl) begin
        rxbaud_r <= i_wdata[`CRT_B_RXBAUD];
        txbaud_r <= i_wdata[`CRT_B_TXBAUD];
        exen_r <= i_wdata[`CRT_B_EXEN];
        run_r <= i_wdata[`CRT_B_RUN];
        cts_r <= i_wdata[`CRT_B_CTS];
        cprl_r <= i_wdata[`CRT_B_CPRL];
      end
      if (wr_mode) begin
        down_count_enable_r <= i_wdata[`CRT_B_DOWN_COUNT_ENABLE];
        clkoe_r <= i_wdata[`CRT_B_CLKOE];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= `CRT_RST_WORD;
      rcap_r <= `CRT_RST_WORD;
    end else begin
      cnt_r <= cnt_nxt;
      rcap_r <= rcap_nxt;
    end
  end

  // ==================================================
  // read data, baud tick and clock out
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_r <= `CRT_RST_BYTE;
      baud_tick_r <= 1'b0;
      clk_out_r <= 1'b0;
    end else begin
      rdata_r <= i_rd ? rd_mux : `CRT_RST_BYTE;
      baud_tick_r <= wrap & baud;
      if (wrap && clkoe_r && !cts_r) begin
        clk_out_r <= ~clk_out_r;
      end
    end
  end

  assign o_rdata = rdata_r;
  assign o_baud_tick = baud_tick_r;
  assign o_clock_out = clk_out_r;
  assign o_timer_irq = ovf_r | (exf_r & ~updn);
endmodule
